// *** bench/sarc_analog.sv ***
// Far-side model: analog channels, track-and-hold and comparator
module sarc_analog (
	// Clock and core side
	input wire logic        clk_i,
	input wire logic        core_on_i,
	input wire logic        sampling_i,
	input wire logic [11:0] chan_sel_i,
	input wire logic [9:0]  dac_code_i,
	// Channel levels as ideal codes
	input wire logic [9:0]  lvl_i [12],
	output logic            cmp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] held_q = 10'h000;
	logic       junk_q = 1'b0;
	always @(posedge clk_i) begin
		junk_q <= ~junk_q;
		for (int c = 0; c < 12; c++) begin
			if (sampling_i && chan_sel_i[c]) begin
				held_q <= lvl_i[c];
			end
		end
	end
	// Unpowered core answers garbage, not a stale value
	assign cmp_o = core_on_i ? (held_q >= dac_code_i) : junk_q;
endmodule

// *** bench/sarc_sva.sv ***
// Checker for the converter control top ports
module sarc_sva (
	// Clock, reset, register port
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic [3:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	// Analog controls and status
	input wire logic        core_power_on_o,
	input wire logic        sampling_o,
	input wire logic [11:0] chan_sel_o,
	input wire logic        bandgap_on_o,
	input wire logic        ref_buffer_on_o,
	input wire logic        reference_output_enable_o,
	input wire logic        conversion_busy_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_core_follows: assert property (wr_i && addr_i == 4'h0 |=>
		core_power_on_o == $past(wdata_i[2])) else $error("core power not as written");
	a_bandgap_follows: assert property (wr_i && addr_i == 4'h0 |=>
		bandgap_on_o == $past(wdata_i[3])) else $error("band-gap not as written");
	a_buf_needs_bg: assert property (!bandgap_on_o |-> !ref_buffer_on_o)
		else $error("buffer on without reference");
	a_buf_idle_off: assert property (!conversion_busy_flag_o && !reference_output_enable_o
		|-> !ref_buffer_on_o) else $error("buffer on while idle");
	a_buf_sampling: assert property (sampling_o && bandgap_on_o |-> ref_buffer_on_o)
		else $error("buffer off while sampling");
	a_mux_break: assert property (!sampling_o |-> chan_sel_o == 12'h000)
		else $error("channel selected outside sampling");
	a_sample_min: assert property ($rose(sampling_o) |-> sampling_o[*4])
		else $error("sampling shorter than four clocks");
	a_busy_covers: assert property (sampling_o |-> conversion_busy_flag_o)
		else $error("sampling without busy");
	a_off_no_busy: assert property (!core_power_on_o |=> !conversion_busy_flag_o)
		else $error("busy with core off");
	a_busy_ends: assert property ($rose(conversion_busy_flag_o)
		|-> ##[1:1000] !conversion_busy_flag_o) else $error("conversion never ends");
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
		else $error("read data outside read slot");
	c_busy: cover property ($rose(conversion_busy_flag_o));
	c_sample: cover property ($fell(sampling_o));
	c_buffer: cover property ($rose(ref_buffer_on_o));
endmodule

bind sarc_top sarc_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.core_power_on_o(core_power_on_o), .sampling_o(sampling_o), .chan_sel_o(chan_sel_o),
	.bandgap_on_o(bandgap_on_o), .ref_buffer_on_o(ref_buffer_on_o),
	.reference_output_enable_o(reference_output_enable_o),
	.conversion_busy_flag_o(conversion_busy_flag_o));

// *** bench/sarc_top_bench.sv ***
// Bench for the converter control block
module sarc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [3:0]  src_tick_i = 4'h0;
	logic [3:0]  trig_i = 4'h0;
	logic [9:0]  res_exp = 10'h000;
	logic        cmp_i;
	logic [15:0] rdata_o;
	logic [9:0]  dac_o;
	logic [11:0] sel_o;
	logic [7:0]  ape_o;
	logic        core_o, samp_o, bg_o, rbuf_o, lvl_o, ext_o, slew_o, rout_o, busy_o;
	logic [9:0]  lvl [12];
	logic [15:0] d, x, w;
	logic [11:0] sel;
	int          errors = 0;
	int          checked = 0;
	int          ns, nc, n;
	always #20 clk_i = ~clk_i;
	sarc_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_tick_i(src_tick_i),
		.trig_src_i(trig_i), .cmp_i(cmp_i), .dac_code_o(dac_o), .core_power_on_o(core_o),
		.sampling_o(samp_o), .chan_sel_o(sel_o), .analog_pin_enable_o(ape_o),
		.bandgap_on_o(bg_o), .ref_buffer_on_o(rbuf_o), .reference_level_high_o(lvl_o),
		.ext_ref_buffered_o(ext_o), .buffer_low_slew_o(slew_o),
		.reference_output_enable_o(rout_o), .conversion_busy_flag_o(busy_o));
	sarc_analog far (.clk_i(clk_i), .core_on_i(core_o), .sampling_i(samp_o),
		.chan_sel_i(sel_o), .dac_code_i(dac_o), .lvl_i(lvl), .cmp_o(cmp_i));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("Counts: %0d compared, %0d mismatched", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	function automatic logic [15:0] samp_cycles(input logic [1:0] c, input logic [2:0] dv);
		logic [15:0] t;
		t = (c == 2'h0) ? 16'h0004 : (c == 2'h1) ? 16'h0008 : (c == 2'h2) ? 16'h0010 : 16'h0040;
		return t * (16'(dv) + 16'h0001);
	endfunction
	task automatic convert(input logic [1:0] src, input logic [2:0] dv, input logic [1:0] sl,
		input logic [3:0] ch, input logic tw, input logic [1:0] tg, input logic inv,
		input logic [3:0] rf);
		logic [15:0] c1;
		logic [9:0]  e;
		logic        bon;
		c1 = {3'h0, ch, src, dv, tg, inv, tw};
		e = tw ? {~lvl[ch][9], lvl[ch][8:0]} : lvl[ch];
		res_exp = e;
		bon = 1'b0;
		wr(sarc_pkg::OFS_CTRL0, 16'h0000);
		trig_i <= {4{inv}};
		wr(sarc_pkg::OFS_CTRL1, c1);
		src_tick_i <= 4'h1 << src;
		// Low slew stays off: ticks here run far above its rate limit
		wr(sarc_pkg::OFS_CTRL0, {4'h0, sl, 3'h0, rf, 1'b1, (tg == 2'h0), 1'b1});
		if (tg != 2'h0) begin
			trig_i[tg] <= ~inv;
		end
		ns = 0;
		nc = 0;
		for (n = 0; n < 2000 && !(ns > 0 && !busy_o); n++) begin
			@(posedge clk_i);
			#1;
			nc += (busy_o && !samp_o && ns > 0) ? 1 : 0;
			if (samp_o) begin
				ns++;
				sel = sel_o;
				bon = rbuf_o;
			end
		end
		if (n == 2000) begin
			errors++;
			finish_test();
		end
		check(16'(ns), samp_cycles(sl, dv));
		check(16'(nc), 16'h000B * (16'(dv) + 16'h0001));
		check({4'h0, sel}, 16'h0001 << ch);
		check({15'h0000, bon}, {15'h0000, rf[0]});
		check({15'h0000, rbuf_o}, {15'h0000, rf[0] & rf[2] & ~rf[3]});
		rd(sarc_pkg::OFS_RESULT, d);
		check(d, {6'h00, e});
		wr(sarc_pkg::OFS_CTRL1, ~c1);
		rd(sarc_pkg::OFS_CTRL1, d);
		check(d, c1);
		rd(sarc_pkg::OFS_STATUS, d);
		check(d, 16'h0000);
		$display("Conversion on channel %0d done", ch);
	endtask
	initial begin
		void'($urandom(85760));
		foreach (lvl[i]) lvl[i] = 10'($urandom);
		lvl[0] = 10'h000;
		lvl[11] = 10'h3FF;
		repeat (8) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		for (int a = 0; a < 6; a++) begin
			rd((a == 5) ? 4'hF : 4'(a), d);
			check(d, 16'h0000);
		end
		$display("Reset test done");
		for (int i = 0; i < 8; i++) begin
			w = 16'($urandom) & 16'h03FC;
			wr(sarc_pkg::OFS_CTRL0, w);
			wr(sarc_pkg::OFS_APE, {8'h00, w[9:2]});
			#1;
			x = {9'h000, w[9] & w[8], w[7], w[5], w[4], w[3], w[2], w[3] & w[5] & ~w[6]};
			check({9'h000, ext_o, slew_o, rout_o, lvl_o, bg_o, core_o, rbuf_o}, x);
			check({8'h00, ape_o}, {8'h00, w[9:2]});
		end
		$display("Config test done");
		src_tick_i <= 4'hF;
		wr(sarc_pkg::OFS_CTRL0, 16'h0006);
		repeat (20) begin
			@(posedge clk_i);
			#1;
			check({15'h0000, busy_o}, 16'h0000);
		end
		$display("Disabled trigger test done");
		convert(2'h0, 3'h0, 2'h0, 4'h0, 1'b0, 2'h0, 1'b0, 4'h1);
		convert(2'h3, 3'h7, 2'h3, 4'hB, 1'b1, 2'h3, 1'b1, 4'hD);
		for (int i = 0; i < 12; i++) begin
			convert(2'($urandom), 3'($urandom), 2'($urandom % 3), 4'(i), 1'($urandom),
				2'($urandom), 1'($urandom), 4'($urandom));
		end
		// Stopped conversion clock: busy holds, abort leaves the old result
		src_tick_i <= 4'h1;
		wr(sarc_pkg::OFS_CTRL0, 16'h0000);
		wr(sarc_pkg::OFS_CTRL1, 16'h0200);
		wr(sarc_pkg::OFS_CTRL0, 16'h0007);
		repeat (8) @(posedge clk_i);
		src_tick_i <= 4'h0;
		repeat (100) @(posedge clk_i);
		#1;
		check({15'h0000, busy_o}, 16'h0001);
		wr(sarc_pkg::OFS_CTRL0, 16'h0000);
		@(posedge clk_i);
		#1;
		check({15'h0000, busy_o}, 16'h0000);
		rd(sarc_pkg::OFS_RESULT, d);
		check(d, {6'h00, res_exp});
		$display("Stopped clock test done");
		finish_test();
	end
endmodule

// *** logic/sarc_clk_div.sv ***
// Conversion clock source select and 1..8 divider, as a tick in clk domain
module sarc_clk_div (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Clock source enables
	input  wire logic [3:0] src_tick_i,
	// Control and tick
	sarc_tick_if.gen        tk
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic       src_hit;
	logic       wrap;

	assign src_hit = src_tick_i[tk.src_sel]; // [RL7]
	assign wrap    = (cnt_q >= tk.div_ratio);
	assign cnt_d   = !src_hit ? cnt_q : (wrap ? 3'h0 : cnt_q + 3'h1);
	assign tk.tick = src_hit && wrap; // [RL7]

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// *** logic/sarc_pkg.sv ***
// Package for the converter control block: offsets, fields, reset values, timing
package sarc_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned RES_W  = 10;
	localparam logic [RES_W-1:0] RES_FULL = 10'h3FF;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL0  = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL1  = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_APE    = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;

	// Control word 0 fields
	localparam int unsigned C0_ENABLE     = 0;
	localparam int unsigned C0_SOFT_START = 1;
	localparam int unsigned C0_CORE_ON    = 2;
	localparam int unsigned C0_REF_ON     = 3;
	localparam int unsigned C0_REF_HIGH   = 4;
	localparam int unsigned C0_REF_OUT    = 5;
	localparam int unsigned C0_BURST      = 6;
	localparam int unsigned C0_LOW_SLEW   = 7;
	localparam int unsigned C0_SEL_LOW    = 8;
	localparam int unsigned C0_SEL_HIGH   = 9;
	localparam int unsigned C0_SAMPLE_LO  = 10;
	localparam int unsigned C0_SAMPLE_W   = 2;

	// Control word 1 fields
	localparam int unsigned C1_TWOS       = 0;
	localparam int unsigned C1_TRIG_INV   = 1;
	localparam int unsigned C1_TRIG_LO    = 2;
	localparam int unsigned C1_TRIG_W     = 2;
	localparam int unsigned C1_DIV_LO     = 4;
	localparam int unsigned C1_DIV_W      = 3;
	localparam int unsigned C1_SRC_LO     = 7;
	localparam int unsigned C1_SRC_W      = 2;
	localparam int unsigned C1_CHAN_LO    = 9;
	localparam int unsigned C1_CHAN_W     = 4;

	// Status fields
	localparam int unsigned ST_BUSY      = 0;
	localparam int unsigned ST_SAMPLING  = 1;

	localparam logic [DATA_W-1:0] CTRL0_RST = 16'h0000;
	localparam logic [DATA_W-1:0] CTRL1_RST = 16'h0000;
	localparam logic [7:0]        APE_RST   = 8'h00;

	localparam int unsigned NUM_CHAN  = 12;
	localparam int unsigned CONV_CYC  = 11;
	localparam int unsigned CNT_W     = 7;
	// Sample periods selectable: 4, 8, 16, 64 conversion clocks
	localparam logic [CNT_W-1:0] SAMP_4  = 7'h04;
	localparam logic [CNT_W-1:0] SAMP_8  = 7'h08;
	localparam logic [CNT_W-1:0] SAMP_16 = 7'h10;
	localparam logic [CNT_W-1:0] SAMP_64 = 7'h40;

	typedef enum logic [1:0] {
		SRC_OSC,
		SRC_AUX,
		SRC_MAIN,
		SRC_SUB
	} sarc_src_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT
	} sarc_state_t;
endpackage

// *** logic/sarc_tick_if.sv ***
// Interface carrying the divided conversion clock tick between modules
interface sarc_tick_if;
	logic [1:0] src_sel;
	logic [2:0] div_ratio;
	logic       tick;
	modport gen (input src_sel, input div_ratio, output tick);
	modport use_ (output src_sel, output div_ratio, input tick);
endinterface

// *** logic/sarc_top.sv ***
// Converter control: registers, reference power, channel select, conversion sequencer
//
// Behaviour
// RL1 - Result is 10 bits, all ones at or above upper ref, zero at/below lower.
// RL2 - Result format selectable: straight binary or two's complement.
// RL3 - Straight binary code scales linearly with input across the reference span.
// RL4 - Core powered only while core power-on bit set.
// RL5 - Most config bits are write-locked while conversion enable is set.
// RL6 - No conversion starts unless conversion enable is set.
// RL7 - Conversion clock from four sources, divided by one to eight.
// RL8 - Same divided clock steps conversion and times sampling.
// RL9 - Software keeps chosen clock running; stopping it aborts the result. Here the sequencer stalls, busy held until enable or power drops.
// RL10 - Select one of eight external, four internal channels, break-before-make.
// RL11 - Analog pin enable bits disable pin input and output buffers.
// RL12 - Reference-on enables band-gap and buffer together; off disables both.
// RL13 - Level-select one picks high reference level, zero picks low.
// RL14 - Both reference-select bits set buffers external positive reference.
// RL15 - Reference on but idle: buffer off, band-gap stays on.
// RL16 - Reference output on: burst zero keeps buffer on, one only while active.
// RL17 - Low-slew buffer bit only advised below the stated rate limit.
// RL18 - Conversion begins on rising edge of trigger, polarity invertible.
// RL19 - Conversion completes in eleven conversion clocks after sampling.
// RL20 - Busy flag from trigger acceptance until result written.
module sarc_top (
	// Clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           rst_b_i,
	// Register port
	input  wire logic [sarc_pkg::ADDR_W-1:0]    addr_i,
	input  wire logic [sarc_pkg::DATA_W-1:0]    wdata_i,
	input  wire logic                           wr_i,
	input  wire logic                           rd_i,
	output logic      [sarc_pkg::DATA_W-1:0]    rdata_o,
	// Clock sources, one-cycle enables: osc, aux, main, sub
	input  wire logic [3:0]                     src_tick_i,
	// External triggers
	input  wire logic [3:0]                     trig_src_i,
	// SAR comparator from analog core
	input  wire logic                           cmp_i,
	output logic      [sarc_pkg::RES_W-1:0]     dac_code_o,
	// Analog control
	output logic                                core_power_on_o,
	output logic                                sampling_o,
	output logic      [sarc_pkg::NUM_CHAN-1:0]  chan_sel_o,
	output logic      [7:0]                     analog_pin_enable_o,
	output logic                                bandgap_on_o,
	output logic                                ref_buffer_on_o,
	output logic                                reference_level_high_o,
	output logic                                ext_ref_buffered_o,
	output logic                                buffer_low_slew_o,
	output logic                                reference_output_enable_o,
	// Status
	output logic                                conversion_busy_flag_o
);
	localparam int unsigned DW = sarc_pkg::DATA_W;
	localparam int unsigned RW = sarc_pkg::RES_W;

	// Reset release
	logic rst_s1_q;
	logic rst_b;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_q <= 1'b0;
			rst_b    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_b    <= rst_s1_q;
		end
	end

	// Registers
	logic [DW-1:0] ctrl0_q;
	logic [DW-1:0] ctrl0_d;
	logic [DW-1:0] ctrl1_q;
	logic [DW-1:0] ctrl1_d;
	logic [7:0]    ape_q;
	logic [7:0]    ape_d;
	logic [RW-1:0] result_q;
	logic [RW-1:0] result_d;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] rdata_d;

	// Sequencer state
	sarc_pkg::sarc_state_t state_q;
	sarc_pkg::sarc_state_t state_d;
	logic [sarc_pkg::CNT_W-1:0] cnt_q;
	logic [sarc_pkg::CNT_W-1:0] cnt_d;
	logic [RW-1:0] sar_q;
	logic [RW-1:0] sar_d;
	logic [RW-1:0] bit_q;
	logic [RW-1:0] bit_d;
	logic          trig_q;
	logic          trig_d;
	logic          pend_q;
	logic          pend_d;
	logic          busy_q;
	logic          busy_d;

	// Field views
	wire logic enable     = ctrl0_q[sarc_pkg::C0_ENABLE];
	wire logic core_on    = ctrl0_q[sarc_pkg::C0_CORE_ON];
	wire logic ref_on     = ctrl0_q[sarc_pkg::C0_REF_ON];
	wire logic ref_out    = ctrl0_q[sarc_pkg::C0_REF_OUT];
	wire logic burst      = ctrl0_q[sarc_pkg::C0_BURST];
	wire logic twos       = ctrl1_q[sarc_pkg::C1_TWOS];
	wire logic trig_inv   = ctrl1_q[sarc_pkg::C1_TRIG_INV];
	wire logic [1:0] samp_sel  = ctrl0_q[sarc_pkg::C0_SAMPLE_LO +: sarc_pkg::C0_SAMPLE_W];
	wire logic [1:0] trig_sel  = ctrl1_q[sarc_pkg::C1_TRIG_LO +: sarc_pkg::C1_TRIG_W];
	wire logic [3:0] chan      = ctrl1_q[sarc_pkg::C1_CHAN_LO +: sarc_pkg::C1_CHAN_W];

	// Clock divider
	sarc_tick_if tk ();
	assign tk.src_sel   = ctrl1_q[sarc_pkg::C1_SRC_LO +: sarc_pkg::C1_SRC_W]; // [RL7]
	assign tk.div_ratio = ctrl1_q[sarc_pkg::C1_DIV_LO +: sarc_pkg::C1_DIV_W]; // [RL7]

	sarc_clk_div u_div (
		.clk        (clk_i),
		.rst_b      (rst_b),
		.src_tick_i (src_tick_i),
		.tk         (tk.gen)
	);

	wire logic tick = tk.tick;

	// Bus decode
	wire logic hit_c0  = wr_i && (addr_i == sarc_pkg::OFS_CTRL0);
	wire logic hit_c1  = wr_i && (addr_i == sarc_pkg::OFS_CTRL1);
	wire logic hit_ape = wr_i && (addr_i == sarc_pkg::OFS_APE);

	// Enable, start, and power bits stay writable; the rest lock while enabled
	wire logic [DW-1:0] c0_free = 16'h000F;
	assign ctrl0_d = hit_c0 ? (enable ? ((ctrl0_q & ~c0_free) | (wdata_i & c0_free)) // [RL5]
	                                  : wdata_i)
	                        : (ctrl0_q & ~(16'h0001 << sarc_pkg::C0_SOFT_START));
	assign ctrl1_d = (hit_c1 && !enable) ? wdata_i : ctrl1_q; // [RL5]
	assign ape_d   = (hit_ape && !enable) ? wdata_i[7:0] : ape_q; // [RL5]

	// Trigger select and polarity
	wire logic [3:0] trig_vec  = {trig_src_i[3:1], ctrl0_q[sarc_pkg::C0_SOFT_START]};
	wire logic       trig_lvl  = trig_vec[trig_sel] ^ trig_inv; // [RL18]
	wire logic       trig_rise = trig_lvl && !trig_q; // [RL18]
	assign trig_d = trig_lvl;

	// Sample period lookup
	logic [sarc_pkg::CNT_W-1:0] samp_len;
	assign samp_len = (samp_sel == 2'd0) ? sarc_pkg::SAMP_4 :
	                  (samp_sel == 2'd1) ? sarc_pkg::SAMP_8 :
	                  (samp_sel == 2'd2) ? sarc_pkg::SAMP_16 : sarc_pkg::SAMP_64;

	// Trial code and final result
	wire logic [RW-1:0] trial    = sar_q | bit_q;
	wire logic [RW-1:0] sar_keep = cmp_i ? trial : sar_q; // [RL1] [RL3]
	wire logic [RW-1:0] fmt_res  = twos ? {~sar_keep[RW-1], sar_keep[RW-2:0]} : sar_keep; // [RL2]
	wire logic          accept   = trig_rise && enable && core_on && (state_q == sarc_pkg::ST_IDLE);

	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		sar_d    = sar_q;
		bit_d    = bit_q;
		pend_d   = pend_q;
		busy_d   = busy_q;
		result_d = result_q;
		unique case (state_q)
			sarc_pkg::ST_IDLE: begin
				if (accept) begin // [RL6]
					pend_d = 1'b1;
					busy_d = 1'b1; // [RL20]
				end
				// Sampling begins on the next conversion clock for alignment
				if (pend_q && tick) begin
					pend_d  = 1'b0;
					state_d = sarc_pkg::ST_SAMPLE;
					cnt_d   = samp_len - 7'h01;
				end
			end
			sarc_pkg::ST_SAMPLE: begin
				if (tick) begin // [RL8]
					if (cnt_q == 7'h00) begin
						state_d = sarc_pkg::ST_CONVERT;
						cnt_d   = 7'(sarc_pkg::CONV_CYC - 1);
						sar_d   = '0;
						bit_d   = 10'h200;
					end else begin
						cnt_d = cnt_q - 7'h01;
					end
				end
			end
			sarc_pkg::ST_CONVERT: begin
				if (tick) begin // [RL8] [RL19]
					if (bit_q != '0) begin
						sar_d = sar_keep;
						bit_d = bit_q >> 1;
					end
					if (cnt_q == 7'h00) begin
						state_d  = sarc_pkg::ST_IDLE;
						result_d = fmt_res; // [RL1] [RL2]
						busy_d   = 1'b0; // [RL20]
					end else begin
						cnt_d = cnt_q - 7'h01;
					end
				end
			end
			// Unused fourth code falls back to idle
			default: state_d = sarc_pkg::ST_IDLE;
		endcase
		// Dropping enable or power aborts; result left untouched
		if (!enable || !core_on) begin // [RL9]
			state_d = sarc_pkg::ST_IDLE;
			pend_d  = 1'b0;
			busy_d  = 1'b0;
		end
	end

	// Read mux
	assign rdata_d = !rd_i ? '0 :
	                 (addr_i == sarc_pkg::OFS_CTRL0)  ? ctrl0_q :
	                 (addr_i == sarc_pkg::OFS_CTRL1)  ? ctrl1_q :
	                 (addr_i == sarc_pkg::OFS_APE)    ? {8'h00, ape_q} :
	                 (addr_i == sarc_pkg::OFS_RESULT) ? {6'h00, result_q} :
	                 (addr_i == sarc_pkg::OFS_STATUS) ?
	                     {14'h0000, (state_q == sarc_pkg::ST_SAMPLE), busy_q} : '0;

	// Control registers; short groups keep each reset branch easy to audit
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			ctrl0_q <= sarc_pkg::CTRL0_RST;
			ctrl1_q <= sarc_pkg::CTRL1_RST;
			ape_q   <= sarc_pkg::APE_RST;
		end else begin
			ctrl0_q <= ctrl0_d;
			ctrl1_q <= ctrl1_d;
			ape_q   <= ape_d;
		end
	end

	// Result and read data
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			result_q <= '0;
			rdata_q  <= '0;
		end else begin
			result_q <= result_d;
			rdata_q  <= rdata_d;
		end
	end

	// Sequencer state and its counter
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= sarc_pkg::ST_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Successive approximation register and trial bit
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			sar_q <= '0;
			bit_q <= '0;
		end else begin
			sar_q <= sar_d;
			bit_q <= bit_d;
		end
	end

	// Trigger history, pending start and busy
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			trig_q <= 1'b0;
			pend_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			trig_q <= trig_d;
			pend_q <= pend_d;
			busy_q <= busy_d;
		end
	end

	// Outputs
	wire logic active = (state_q != sarc_pkg::ST_IDLE);
	assign rdata_o                = rdata_q;
	assign core_power_on_o        = core_on; // [RL4]
	assign sampling_o             = (state_q == sarc_pkg::ST_SAMPLE);
	// Break-before-make: no channel connected outside sampling
	assign chan_sel_o             = sampling_o && (chan < 4'(sarc_pkg::NUM_CHAN))
	                                ? (12'h001 << chan) : 12'h000; // [RL10]
	assign dac_code_o             = trial;
	assign analog_pin_enable_o    = ape_q; // [RL11]
	assign bandgap_on_o           = ref_on; // [RL12] [RL15]
	assign ref_buffer_on_o        = ref_on && (active || (ref_out && !burst)); // [RL12] [RL15] [RL16]
	assign reference_level_high_o = ctrl0_q[sarc_pkg::C0_REF_HIGH]; // [RL13]
	assign ext_ref_buffered_o     = ctrl0_q[sarc_pkg::C0_SEL_LOW]
	                                && ctrl0_q[sarc_pkg::C0_SEL_HIGH]; // [RL14]
	assign buffer_low_slew_o      = ctrl0_q[sarc_pkg::C0_LOW_SLEW];
	assign reference_output_enable_o = ref_out;
	assign conversion_busy_flag_o = busy_q; // [RL20]
endmodule
